// File: rtl/lrx_pkg.sv
// constants shared by the line receiver alarm and output logic
package lrx_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // frequency supervision: window of reference edges and tolerance
    localparam int unsigned FREQ_WIN = 1024;
    localparam int unsigned FREQ_TOL_PERMILLE = 5;
    localparam int unsigned FREQ_TOL = FREQ_WIN * FREQ_TOL_PERMILLE / 1000;
    // digital loss-of-signal detector
    localparam int unsigned ZERO_RUN = 160;
    localparam int unsigned ONES_WIN = 32;
    localparam int unsigned ONES_MIN = 8;
    // least alarm pulse width in recovered clock cycles
    localparam int unsigned MIN_PULSE = 32;
    // line input to rail output latency in recovered clock cycles
    localparam int unsigned PIPE_DEPTH = 3;
    // acquisition limits
    localparam int unsigned PHASE_HIT_MS = 2;
    localparam int unsigned ACQ_MS = 20;
    localparam int unsigned PHASE_HIT_CYC = CLK_HZ / 1000 * PHASE_HIT_MS;
    localparam int unsigned ACQ_CYC = CLK_HZ / 1000 * ACQ_MS;
endpackage

// File: rtl/lrx_freq_cmp.sv
// loop clock against reference clock frequency comparator
`timescale 1ns/1ps
module lrx_freq_cmp #(
    parameter int unsigned WIN = lrx_pkg::FREQ_WIN,
    parameter int unsigned TOL = lrx_pkg::FREQ_TOL
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic loop_tick_i,
    input wire logic ref_i,
    output logic done_o,
    output logic err_o
);
    import lrx_pkg::*;

    logic ref_q;
    logic [15:0] ref_cnt_q;
    logic [15:0] loop_cnt_q;
    logic ref_rise;
    logic win_end;
    logic [15:0] loop_next;
    logic [15:0] dev;

    assign ref_rise = ref_i & ~ref_q;
    assign win_end = ref_rise && (ref_cnt_q == 16'(WIN - 1));
    // saturate so a runaway loop still reads as far off
    assign loop_next = (loop_cnt_q == 16'hFFFF) ? loop_cnt_q :
                       loop_cnt_q + 16'(loop_tick_i);
    assign dev = (loop_next > 16'(WIN)) ? loop_next - 16'(WIN) :
                 16'(WIN) - loop_next;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ref_q <= 1'b0;
            ref_cnt_q <= 16'h0000;
            loop_cnt_q <= 16'h0000;
            done_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ref_q <= ref_i;
            done_o <= win_end;
            if (win_end) begin
                ref_cnt_q <= 16'h0000;
                loop_cnt_q <= 16'h0000;
                err_o <= dev > 16'(TOL); // R01
            end else begin
                ref_cnt_q <= ref_cnt_q + 16'(ref_rise);
                loop_cnt_q <= loop_next;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_window_length: assert property ( // R01
        done_o |-> $past(ref_cnt_q) == 16'(WIN - 1))
        else $error("comparison window ended at wrong count");
endmodule // lrx_freq_cmp

// File: rtl/lrx_los_det.sv
// digital ones-density loss-of-signal detector
`timescale 1ns/1ps
module lrx_los_det #(
    parameter int unsigned RUN = lrx_pkg::ZERO_RUN,
    parameter int unsigned ONES = lrx_pkg::ONES_MIN
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic bit_stb_i,
    input wire logic bit_one_i,
    output logic los_o
);
    import lrx_pkg::*;

    logic [7:0] zero_cnt_q;
    logic [ONES_WIN-1:0] hist_q;
    logic [5:0] ones_cnt_q;
    logic [5:0] ones_next;
    logic run_hit;

    // running count of ones in the last ONES_WIN bits
    assign ones_next = ones_cnt_q + 6'(bit_one_i) - 6'(hist_q[ONES_WIN-1]);
    assign run_hit = !bit_one_i && (zero_cnt_q >= 8'(RUN - 1));

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            zero_cnt_q <= 8'h00;
            hist_q <= '0;
            ones_cnt_q <= 6'h00;
            los_o <= 1'b0;
        end else if (bit_stb_i) begin
            hist_q <= {hist_q[ONES_WIN-2:0], bit_one_i};
            ones_cnt_q <= ones_next;
            if (bit_one_i) begin
                zero_cnt_q <= 8'h00;
            end else if (!run_hit) begin
                zero_cnt_q <= zero_cnt_q + 8'h01;
            end
            if (run_hit) begin
                los_o <= 1'b1; // R06
            end else if (ones_next >= 6'(ONES)) begin
                los_o <= 1'b0; // R07
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_zero_run_sets: assert property ( // R06
        bit_stb_i && run_hit |=> los_o)
        else $error("zero run did not raise loss");
    a_clear_needs_ones: assert property ( // R07
        $fell(los_o) |-> $past(ones_next) >= 6'(ONES))
        else $error("loss cleared without enough ones");
endmodule // lrx_los_det

// File: rtl/lrx_line_rx.sv
// line receiver supervision, alarms and dual-rail output stage
`timescale 1ns/1ps
// What this block does
// R01: compare loop clock with reference; past half percent force reacquire.
// R02: raise lock alarm on frequency error or 180 degree data alignment.
// R03: lock alarm stays until frequency lock, at least 32 clock cycles.
// R04: loss alarm high when analog or digital detector reports loss.
// R05: loss alarm held high at least 32 clock cycles once raised.
// R06: digital detector raises loss after 160 consecutive zeros.
// R07: digital loss clears only with eight ones in 32 bits.
// R08: recovery keeps running regardless of the loss alarm.
// R09: threshold select fixed at power-up, never changed in operation.
// R10: rails change at recovered clock rise, valid at falling edge.
// R11: positive mark drives positive rail, negative the other, zero neither.
// R12: each symbol appears on rails three recovered clock cycles later.
// R13: float test low puts all five outputs into high impedance.
// R14: regain operation within 2 ms after a 180 degree phase hit.
// R15: reach operation within 20 ms of power-up with valid input.
// R16: digital detector counts a one when either rail is high.
module lrx_line_rx #(
    parameter int unsigned PHASE_HIT_CYC = lrx_pkg::PHASE_HIT_CYC,
    parameter int unsigned ACQ_CYC = lrx_pkg::ACQ_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic line_pos_i,
    input wire logic line_neg_i,
    input wire logic line_stb_i,
    input wire logic reference_clock_in_i,
    input wire logic phase_inverted_i,
    input wire logic analog_los_i,
    input wire logic output_float_test_i,
    input wire logic [1:0] loss_threshold_select_i,
    output logic recovered_clock_o,
    output logic recovered_clock_oe_o,
    output logic positive_rail_data_o,
    output logic positive_rail_data_oe_o,
    output logic negative_rail_data_o,
    output logic negative_rail_data_oe_o,
    output logic signal_loss_alarm_o,
    output logic signal_loss_alarm_oe_o,
    output logic lock_loss_alarm_o,
    output logic lock_loss_alarm_oe_o,
    output logic reacquire_o,
    output logic [1:0] loss_threshold_o
);
    import lrx_pkg::*;

    // ------------------------------------------------------------
    // output pipeline
    // ------------------------------------------------------------
    logic [PIPE_DEPTH-2:0] pos_pipe_q;
    logic [PIPE_DEPTH-2:0] neg_pipe_q;
    logic rclk_q;
    logic pos_q;
    logic neg_q;
    logic oe_q;
    logic mark_pos;
    logic mark_neg;

    // both inputs high is not a valid mark and is taken as a zero
    assign mark_pos = line_pos_i & ~line_neg_i; // R11
    assign mark_neg = line_neg_i & ~line_pos_i; // R11

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pos_pipe_q <= '0;
            neg_pipe_q <= '0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            rclk_q <= 1'b0;
        end else begin
            rclk_q <= line_stb_i; // R10
            if (line_stb_i) begin
                pos_pipe_q <= {pos_pipe_q[PIPE_DEPTH-3:0], mark_pos}; // R12
                neg_pipe_q <= {neg_pipe_q[PIPE_DEPTH-3:0], mark_neg}; // R12
                pos_q <= pos_pipe_q[PIPE_DEPTH-2]; // R10
                neg_q <= neg_pipe_q[PIPE_DEPTH-2]; // R10
            end
        end
    end

    // ------------------------------------------------------------
    // float test and threshold capture
    // ------------------------------------------------------------
    logic thr_taken_q;
    logic [1:0] thr_q;

    // the pin is sampled once after reset release; later changes are
    // ignored since the analog comparator must not see them
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            oe_q <= 1'b0;
            thr_taken_q <= 1'b0;
            thr_q <= 2'h0;
        end else begin
            oe_q <= output_float_test_i; // R13
            thr_taken_q <= 1'b1;
            if (!thr_taken_q) begin
                thr_q <= loss_threshold_select_i; // R09
            end
        end
    end

    // ------------------------------------------------------------
    // lock supervision
    // ------------------------------------------------------------
    logic freq_done;
    logic freq_err;
    logic lol_q;
    logic [5:0] lol_cnt_q;
    logic startup_q;
    logic [19:0] wd_cnt_q;
    logic reacq_q;
    logic phase_q;
    logic lol_set;
    logic lol_clr;
    logic wd_hit;
    logic lol_min_done;

    lrx_freq_cmp u_freq (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .loop_tick_i(line_stb_i),
        .ref_i(reference_clock_in_i),
        .done_o(freq_done),
        .err_o(freq_err)
    );

    assign lol_min_done = lol_cnt_q == 6'(MIN_PULSE);
    assign lol_set = (freq_done & freq_err) | phase_inverted_i; // R02
    assign lol_clr = freq_done & ~freq_err & lol_min_done; // R03
    // a loop stuck out of lock is kicked again when its time is up
    assign wd_hit = lol_q && (startup_q ? wd_cnt_q == 20'(ACQ_CYC - 1) :
                    wd_cnt_q == 20'(PHASE_HIT_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lol_q <= 1'b1;
            lol_cnt_q <= 6'h00;
            startup_q <= 1'b1;
            wd_cnt_q <= 20'h00000;
            reacq_q <= 1'b0;
            phase_q <= 1'b0;
        end else begin
            phase_q <= phase_inverted_i;
            reacq_q <= (freq_done & freq_err) | wd_hit | // R01
                       (phase_inverted_i & ~phase_q); // R14
            if (lol_set) begin
                lol_q <= 1'b1; // R02
            end else if (lol_clr) begin
                lol_q <= 1'b0; // R03
                startup_q <= 1'b0;
            end
            if (lol_set && !lol_q) begin
                lol_cnt_q <= 6'h00;
            end else if (line_stb_i && !lol_min_done) begin
                lol_cnt_q <= lol_cnt_q + 6'h01; // R03
            end
            if (!lol_q || wd_hit) begin
                wd_cnt_q <= 20'h00000;
            end else begin
                wd_cnt_q <= wd_cnt_q + 20'h00001; // R15
            end
        end
    end

    // ------------------------------------------------------------
    // loss-of-signal alarm
    // ------------------------------------------------------------
    logic dig_los;
    logic los_q;
    logic [5:0] los_cnt_q;
    logic los_raw;
    logic los_min_done;
    logic rail_one;

    assign rail_one = pos_pipe_q[PIPE_DEPTH-2] |
                      neg_pipe_q[PIPE_DEPTH-2]; // R16

    // the detector watches the rails only; it never stalls recovery
    lrx_los_det u_los (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .bit_stb_i(line_stb_i),
        .bit_one_i(rail_one),
        .los_o(dig_los)
    ); // R16 R08

    assign los_raw = analog_los_i | dig_los; // R04
    assign los_min_done = los_cnt_q == 6'(MIN_PULSE);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            los_q <= 1'b0;
            los_cnt_q <= 6'h00;
        end else begin
            if (los_raw) begin
                los_q <= 1'b1; // R04
            end else if (los_min_done) begin
                los_q <= 1'b0; // R05
            end
            if (los_raw && !los_q) begin
                los_cnt_q <= 6'h00;
            end else if (los_q && line_stb_i && !los_min_done) begin
                los_cnt_q <= los_cnt_q + 6'h01; // R05
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign recovered_clock_o = rclk_q;
    assign positive_rail_data_o = pos_q;
    assign negative_rail_data_o = neg_q;
    assign signal_loss_alarm_o = los_q;
    assign lock_loss_alarm_o = lol_q;
    assign recovered_clock_oe_o = oe_q;
    assign positive_rail_data_oe_o = oe_q;
    assign negative_rail_data_oe_o = oe_q;
    assign signal_loss_alarm_oe_o = oe_q;
    assign lock_loss_alarm_oe_o = oe_q;
    assign reacquire_o = reacq_q;
    assign loss_threshold_o = thr_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_freq_bad;
        freq_done && freq_err;
    endsequence

    sequence s_phase_rise;
        phase_inverted_i && !phase_q;
    endsequence

    sequence s_kick_and_alarm;
        reacq_q && lol_q;
    endsequence

    a_freq_reacquire: assert property ( // R01
        s_freq_bad |=> reacq_q ##1 lol_q)
        else $error("frequency error did not force reacquisition");
    a_phase_alarm: assert property ( // R02
        phase_inverted_i |=> lol_q)
        else $error("inverted alignment did not raise lock alarm");
    a_lol_min_width: assert property ( // R03
        $fell(lol_q) |-> $past(lol_cnt_q) == 6'(MIN_PULSE) &&
        $past(freq_done) && !$past(freq_err))
        else $error("lock alarm dropped early or without lock");
    a_los_follows: assert property ( // R04
        analog_los_i |=> los_q)
        else $error("loss alarm missed a detector report");
    a_los_min_width: assert property ( // R05
        $fell(los_q) |-> $past(los_cnt_q) == 6'(MIN_PULSE))
        else $error("loss alarm shorter than least width");
    a_rail_edge: assert property ( // R10
        ($changed(pos_q) || $changed(neg_q)) |-> rclk_q)
        else $error("rail changed away from clock rise");
    a_rail_exclusive: assert property ( // R11
        !(pos_q && neg_q))
        else $error("both rails high");
    a_rail_latency: assert property ( // R12
        line_stb_i |=> pos_q == $past(pos_pipe_q[PIPE_DEPTH-2]))
        else $error("rail output off the three-stage pipeline");
    a_float_oe: assert property ( // R13
        !output_float_test_i |=> !recovered_clock_oe_o &&
        !lock_loss_alarm_oe_o && !signal_loss_alarm_oe_o &&
        !positive_rail_data_oe_o && !negative_rail_data_oe_o)
        else $error("outputs driven during float test");
    a_watchdog_kick: assert property ( // R14
        wd_hit |=> reacq_q)
        else $error("stuck loop was not kicked");
    a_phase_kick: assert property ( // R14
        s_phase_rise |=> s_kick_and_alarm)
        else $error("phase hit did not force reacquisition");
    a_lol_hold: assert property ( // R03
        lol_q && !lol_min_done |=> lol_q)
        else $error("lock alarm dropped before least width");
    a_los_hold: assert property ( // R05
        los_q && !los_min_done |=> los_q)
        else $error("loss alarm dropped before least width");
    a_los_digital: assert property ( // R04
        dig_los |=> los_q)
        else $error("digital detector report missed");
    a_rclk_follows: assert property ( // R10
        line_stb_i |=> rclk_q)
        else $error("recovered clock missed a strobe");
    a_rail_hold: assert property ( // R10
        !line_stb_i |=> $stable(pos_q) && $stable(neg_q))
        else $error("rails moved without a strobe");
    a_thr_frozen: assert property ( // R09
        thr_taken_q |=> $stable(thr_q))
        else $error("threshold code changed in operation");
    a_float_release: assert property ( // R13
        output_float_test_i |=> recovered_clock_oe_o &&
        positive_rail_data_oe_o && negative_rail_data_oe_o)
        else $error("outputs floated in normal operation");
    a_wd_bound: assert property ( // R15
        startup_q |-> wd_cnt_q < 20'(ACQ_CYC))
        else $error("startup kick came late");
    a_wd_phase_bound: assert property ( // R14
        !startup_q && lol_q |-> wd_cnt_q < 20'(PHASE_HIT_CYC))
        else $error("phase hit kick came late");
endmodule // lrx_line_rx

// File: verification/lrx_framer_model.sv
// framer-side model that takes the dual-rail receive outputs
`timescale 1ns/1ps
module lrx_framer_model (
    input wire logic clk_i,
    input wire logic rclk_i,
    input wire logic pos_i,
    input wire logic neg_i,
    output logic [1:0] sym_o
);
    // ----------------------------------------
    // capture
    // ----------------------------------------
    // the recovered clock is a one-cycle pulse, so a high sample here is
    // its falling edge; a floated clock line reads as z and takes nothing
    always @(posedge clk_i) begin
        if (rclk_i === 1'b1) begin
            sym_o <= {pos_i, neg_i};
        end
    end
endmodule // lrx_framer_model

// File: verification/testbench.sv
// self-checking bench for the line receiver alarm and output stage
`timescale 1ns/1ps
module testbench;
    import lrx_pkg::*;
    localparam int PH = 3000;
    localparam int AQ = 6000;
    localparam int WIN3 = 6 * FREQ_WIN + 200;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic stb = 1'b0, lpos = 1'b0, lneg = 1'b0, ref_ck = 1'b0;
    logic ph_inv = 1'b0, a_los = 1'b0, ots = 1'b1, run = 1'b0;
    logic [1:0] thr = 2'h0;
    logic rclk, rclk_oe, pos_o, pos_oe, neg_o, neg_oe;
    logic loss_alm, loss_oe, lock_alm, lock_oe, reacq;
    logic [1:0] thr_o, fr_sym, s, last = 2'h0;
    logic [31:0] r, r0;
    logic fire, fresh = 1'b0;
    logic [1:0] hist[$];
    int seed = 29, gap = 2, ph_cnt = 0, mode = 0, n_reacq = 0, cyc = 0;
    int bad_count = 0, n_tests = 0;
    wire [4:0] oe_v = {rclk_oe, pos_oe, neg_oe, loss_oe, lock_oe};
    wire rclk_w = rclk_oe ? rclk : 1'bz;
    wire pos_w = pos_oe ? pos_o : 1'bz;
    wire neg_w = neg_oe ? neg_o : 1'bz;

    always #12.5 clk_i = ~clk_i;

    lrx_line_rx #(.PHASE_HIT_CYC(PH), .ACQ_CYC(AQ)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .line_pos_i(lpos), .line_neg_i(lneg), .line_stb_i(stb),
        .reference_clock_in_i(ref_ck), .phase_inverted_i(ph_inv),
        .analog_los_i(a_los), .output_float_test_i(ots),
        .loss_threshold_select_i(thr),
        .recovered_clock_o(rclk), .recovered_clock_oe_o(rclk_oe),
        .positive_rail_data_o(pos_o), .positive_rail_data_oe_o(pos_oe),
        .negative_rail_data_o(neg_o), .negative_rail_data_oe_o(neg_oe),
        .signal_loss_alarm_o(loss_alm), .signal_loss_alarm_oe_o(loss_oe),
        .lock_loss_alarm_o(lock_alm), .lock_loss_alarm_oe_o(lock_oe),
        .reacquire_o(reacq), .loss_threshold_o(thr_o)
    );

    lrx_framer_model i_framer (
        .clk_i(clk_i), .rclk_i(rclk_w), .pos_i(pos_w), .neg_i(neg_w),
        .sym_o(fr_sym)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wait_lock(input int lim, input logic v);
        int k;
        k = 0;
        while (lock_alm !== v && k < lim) begin
            @(negedge clk_i);
            k++;
        end
        check(lock_alm, v);
    endtask

    // mode 0 random, 1 zeros, 2 positive marks, 3 negative marks
    task automatic feed(input int m, input int n);
        @(posedge clk_i);
        mode <= m;
        repeat (2 * n) @(negedge clk_i);
    endtask

    // ----------------------------------------
    // stimulus and reference model
    // ----------------------------------------
    // reference edges every 2 clk match the nominal strobe rate
    always @(posedge clk_i) begin
        ref_ck <= ~ref_ck;
        fire = 1'b0;
        if (run) begin
            ph_cnt = ph_cnt + 1;
            fire = (ph_cnt >= gap);
        end
        if (fire) begin
            ph_cnt = 0;
            r = $random(seed);
            s = mode == 0 ? r[1:0] : mode == 1 ? {r[0], r[0]} :
                mode == 2 ? 2'b10 : 2'b01;
            lpos <= s[1];
            lneg <= s[0];
            hist.push_back(s == 2'b11 ? 2'b00 : s);
            if (hist.size() > 3) begin
                hist.pop_front();
            end
        end
        stb <= fire;
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            print_verdict();
        end
    end

    always @(negedge clk_i) begin
        if (reacq === 1'b1) begin
            n_reacq++;
        end
        if (!sys_rst_i && rclk === 1'b1) begin
            last = hist.size() == 3 ? hist[0] : 2'b00;
            check({pos_o, neg_o}, last);
            fresh = (rclk_oe === 1'b1);
        end else if (!sys_rst_i) begin
            check({pos_o, neg_o}, last);
            if (fresh) begin
                check(fr_sym, last);
            end
            fresh = 1'b0;
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        r0 = $random(seed);
        thr <= 2'(r0[3:0] % 4'h3);
        repeat (7) @(posedge clk_i);
        @(negedge clk_i);
        check({rclk, pos_o, neg_o, loss_alm, lock_alm, reacq}, 8'h02);
        check(oe_v, 8'h00);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        run <= 1'b1;
        repeat (3) @(negedge clk_i);
        check(thr_o, thr);
        check(oe_v, 8'h1F);
        wait_lock(AQ, 1'b0);
        @(posedge clk_i);
        ots <= 1'b0;
        repeat (2) @(negedge clk_i);
        check(oe_v, 8'h00);
        @(posedge clk_i);
        ots <= 1'b1;
        repeat (2) @(negedge clk_i);
        check(oe_v, 8'h1F);
        @(posedge clk_i);
        a_los <= 1'b1;
        @(posedge clk_i);
        a_los <= 1'b0;
        @(negedge clk_i);
        check(loss_alm, 1'b1);
        repeat (40) @(negedge clk_i);
        check(loss_alm, 1'b1);
        repeat (40) @(negedge clk_i);
        check(loss_alm, 1'b0);
        feed(1, 120);
        check(loss_alm, 1'b0);
        feed(1, 80);
        check(loss_alm, 1'b1);
        feed(2, 7);
        feed(1, 25);
        check(loss_alm, 1'b1);
        feed(3, 45);
        check(loss_alm, 1'b0);
        feed(0, 10);
        @(posedge clk_i);
        ph_inv <= 1'b1;
        @(posedge clk_i);
        ph_inv <= 1'b0;
        @(negedge clk_i);
        check({lock_alm, reacq}, 8'h03);
        repeat (40) @(negedge clk_i);
        check(lock_alm, 1'b1);
        wait_lock(PH, 1'b0);
        r0 = n_reacq;
        @(posedge clk_i);
        gap <= 4;
        wait_lock(WIN3, 1'b1);
        // the pulse counter shares this edge; let it run first
        @(negedge clk_i);
        check(n_reacq > r0, 1'b1);
        @(posedge clk_i);
        gap <= 2;
        wait_lock(WIN3, 1'b0);
        print_verdict();
    end
endmodule // testbench
